// *** common/ddrmi_pkg.sv ***
package ddrmi_pkg;
    localparam int DQ_W = 8;
    localparam int ADDR_W = 13;
    localparam int BA_W = 2;
    localparam int COL_W = 10;
    // Only the low row bits are stored to keep the array simulatable
    localparam int ROW_KEEP = 4;
    localparam int MEM_AW = BA_W + ROW_KEEP + COL_W;
    localparam int MR_BL_LSB = 0;
    localparam int MR_BL_MSB = 2;
    localparam int MR_BT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_CL_MSB = 6;
    localparam int MR_OP_LSB = 7;
    localparam int MR_DLLRST = 8;
    localparam int AP_BIT = 10;
    localparam int EMR_DLL = 0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] CL_2 = 3'h2;
    localparam logic [2:0] CL_25 = 3'h6;
    localparam logic [1:0] BA_BASE = 2'h0;
    localparam logic [1:0] BA_EXT = 2'h1;
    localparam logic [ADDR_W-1:0] MR_RESET = 13'h0000;
    localparam logic [ADDR_W-1:0] EMR_RESET = 13'h0000;
    localparam logic [7:0] DLL_LOCK_CYC = 8'hc8;
    typedef enum logic [2:0] {
        DDRMI_NOP, DDRMI_ACT, DDRMI_RD, DDRMI_WR, DDRMI_BST, DDRMI_PRE, DDRMI_REF, DDRMI_MRS
    } ddrmi_cmd_t;
endpackage

// *** rtl/ddrmi_burst_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddrmi_burst_seq
    import ddrmi_pkg::*;
(
    input wire logic ck,
    input wire logic rst_n,
    input wire logic start,
    input wire logic stop,
    input wire logic [ddrmi_pkg::COL_W-1:0] start_col_in,
    input wire logic [2:0] bl_code,
    input wire logic interleave_in,
    output logic active,
    output logic [ddrmi_pkg::COL_W-1:0] col_a,
    output logic [ddrmi_pkg::COL_W-1:0] col_b
);
    logic [COL_W-1:0] start_col;
    logic [2:0] mask;
    logic inter;
    logic [1:0] words_m1;
    logic [1:0] kcnt;

    function automatic logic [2:0] col_off(input logic [2:0] s, input logic [2:0] k,
                                           input logic [2:0] m, input logic il);
        col_off = il ? ((s ^ k) & m) : ((s + k) & m);
    endfunction

    assign col_a = {start_col[COL_W-1:3], (start_col[2:0] & ~mask) | col_off(start_col[2:0], {kcnt, 1'b0}, mask, inter)};
    assign col_b = {start_col[COL_W-1:3], (start_col[2:0] & ~mask) | col_off(start_col[2:0], {kcnt, 1'b1}, mask, inter)};

    always_ff @(posedge ck or negedge rst_n) begin
        if (!rst_n) begin
            start_col <= '0;
            mask <= 3'h1;
            inter <= 1'b0;
            words_m1 <= 2'h0;
        end else if (start) begin
            start_col <= start_col_in;
            inter <= interleave_in;
            // length select; reserved codes run as length 2
            case (bl_code)
                BL_4: begin
                    mask <= 3'h3;
                    words_m1 <= 2'h1;
                end
                BL_8: begin
                    mask <= 3'h7;
                    words_m1 <= 2'h3;
                end
                default: begin
                    mask <= 3'h1;
                    words_m1 <= 2'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ck or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
            kcnt <= 2'h0;
        end else if (start) begin
            active <= 1'b1;
            kcnt <= 2'h0;
        end else if (stop || (active && kcnt == words_m1)) begin
            active <= 1'b0;
        end else if (active) begin
            kcnt <= kcnt + 2'h1;
        end
    end

    default clocking cb @(posedge ck); endclocking
    default disable iff (!rst_n);

    AST_BURST_BLOCK: assert property (active |-> col_a[COL_W-1:3] == start_col[COL_W-1:3] && (col_a[2:0] & ~mask) == (start_col[2:0] & ~mask))
        else $error("burst left its aligned block");
    AST_SEQ_ORDER: assert property (start && bl_code == BL_8 && !interleave_in && !stop ##1 !start && !stop |=> col_a[2:0] == $past(start_col_in[2:0], 2) + 3'h2)
        else $error("sequential second word wrong");
    AST_INTL_ORDER: assert property (start && bl_code == BL_8 && interleave_in && !stop ##1 !start && !stop |=> col_b[2:0] == ($past(start_col_in[2:0], 2) ^ 3'h3))
        else $error("interleaved order wrong");
    AST_BURST_LEN: assert property (start && bl_code == BL_4 ##1 !start ##1 !start |=> !active)
        else $error("length four burst too long");
    CV_INTL_BURST: cover property (start && interleave_in && bl_code == BL_8);
    CV_SEQ_BURST: cover property (start && !interleave_in && bl_code == BL_4);
endmodule
`default_nettype wire

// *** rtl/ddrmi_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddrmi_device
    import ddrmi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ck,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [ddrmi_pkg::BA_W-1:0] ba,
    input wire logic [ddrmi_pkg::ADDR_W-1:0] addr,
    input wire logic [ddrmi_pkg::DQ_W-1:0] dq_in,
    output logic [ddrmi_pkg::DQ_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic dqs_out,
    output logic dqs_oe_n,
    output logic dll_enabled,
    output logic dll_locked,
    output logic mode_load_pulse
);
    logic rst_ff1;
    logic rst_link_n;
    ddrmi_cmd_t cmd;
    logic [ADDR_W-1:0] base_mr;
    logic [ADDR_W-1:0] ext_mr;
    logic [7:0] lock_cnt;
    logic [ADDR_W-1:0] refresh_row;
    logic [ADDR_W-1:0] open_row [0:3];
    logic [3:0] row_open;
    logic [BA_W-1:0] burst_bank;
    logic burst_wr;
    logic gen_start;
    logic gen_stop;
    logic gen_active;
    logic [COL_W-1:0] col_a;
    logic [COL_W-1:0] col_b;
    logic [MEM_AW-1:0] mem_a;
    logic [MEM_AW-1:0] mem_b;
    logic [DQ_W-1:0] mem [0:(1<<MEM_AW)-1];
    logic cl25;
    logic s1_v;
    logic s2_v;
    logic [DQ_W-1:0] s1_lo;
    logic [DQ_W-1:0] s1_hi;
    logic [DQ_W-1:0] s2_lo;
    logic [DQ_W-1:0] s2_hi;
    logic [DQ_W-1:0] hi_hold;
    logic hv_hold;
    logic [DQ_W-1:0] rise_q;
    logic rise_v;
    logic [DQ_W-1:0] fall_q;
    logic fall_v;
    logic wr_v;
    logic [MEM_AW-1:0] wr_a;
    logic [MEM_AW-1:0] wr_b;
    logic [DQ_W-1:0] wr_lo;
    logic [DQ_W-1:0] wr_hi;
    logic mrs_tog;
    logic [2:0] tog_sync;
    logic [1:0] en_sync;
    logic [1:0] lock_sync;
    logic lock_done;

    // Reset is released in step with the link clock
    always_ff @(posedge ck or negedge resetn) begin
        if (!resetn) begin
            rst_ff1 <= 1'b0;
            rst_link_n <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_link_n <= rst_ff1;
        end
    end

    // Commands are ignored while the clock enable is low
    always_comb begin
        cmd = DDRMI_NOP;
        if (cke && !cs_n) begin
            case ({ras_n, cas_n, we_n})
                3'b011: cmd = DDRMI_ACT;
                3'b101: cmd = DDRMI_RD;
                3'b100: cmd = DDRMI_WR;
                3'b110: cmd = DDRMI_BST;
                3'b010: cmd = DDRMI_PRE;
                3'b001: cmd = DDRMI_REF;
                3'b000: cmd = DDRMI_MRS;
                default: cmd = DDRMI_NOP;
            endcase
        end
    end

    // Mode registers; array and refresh state are outside this block
    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            base_mr <= MR_RESET;
            ext_mr <= EMR_RESET;
        end else if (cmd == DDRMI_MRS) begin
            if (ba == BA_BASE) begin
                base_mr <= addr;
                base_mr[MR_DLLRST] <= 1'b0;
            end
            if (ba == BA_EXT) begin
                ext_mr <= addr;
            end
        end
    end

    assign cl25 = (base_mr[MR_CL_MSB:MR_CL_LSB] == CL_25);

    // DLL lock timer restarts on a DLL reset or a DLL enable
    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            lock_cnt <= 8'h00;
        end else if (cmd == DDRMI_MRS && ((ba == BA_BASE && addr[MR_DLLRST])
                     || (ba == BA_EXT && addr[EMR_DLL] && !ext_mr[EMR_DLL]))) begin
            lock_cnt <= 8'h00;
        end else if (lock_cnt != DLL_LOCK_CYC) begin
            lock_cnt <= lock_cnt + 8'h01;
        end
    end

    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            refresh_row <= '0;
        end else if (cmd == DDRMI_REF) begin
            refresh_row <= refresh_row + 13'h0001;
        end
    end

    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            row_open <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                open_row[i] <= '0;
            end
        end else if (cmd == DDRMI_ACT) begin
            row_open[ba] <= 1'b1;
            open_row[ba] <= addr;
        end else if (cmd == DDRMI_PRE) begin
            if (addr[AP_BIT]) begin
                row_open <= 4'h0;
            end else begin
                row_open[ba] <= 1'b0;
            end
        end
    end

    assign gen_start = (cmd == DDRMI_RD) || (cmd == DDRMI_WR);
    assign gen_stop = (cmd == DDRMI_BST) && !burst_wr;

    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            burst_bank <= '0;
            burst_wr <= 1'b0;
        end else if (gen_start) begin
            burst_bank <= ba;
            burst_wr <= (cmd == DDRMI_WR);
        end
    end

    ddrmi_burst_seq u_seq (
        .ck(ck),
        .rst_n(rst_link_n),
        .start(gen_start),
        .stop(gen_stop),
        .start_col_in(addr[COL_W-1:0]),
        .bl_code(base_mr[MR_BL_MSB:MR_BL_LSB]),
        .interleave_in(base_mr[MR_BT]),
        .active(gen_active),
        .col_a(col_a),
        .col_b(col_b)
    );

    assign mem_a = {burst_bank, open_row[burst_bank][ROW_KEEP-1:0], col_a};
    assign mem_b = {burst_bank, open_row[burst_bank][ROW_KEEP-1:0], col_b};

    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            s1_v <= 1'b0;
            s1_lo <= '0;
            s1_hi <= '0;
            s2_v <= 1'b0;
            s2_lo <= '0;
            s2_hi <= '0;
        end else begin
            s1_v <= gen_active && !burst_wr;
            s1_lo <= mem[mem_a];
            s1_hi <= mem[mem_b];
            s2_v <= s1_v;
            s2_lo <= s1_lo;
            s2_hi <= s1_hi;
        end
    end

    // launch at edge n plus latency
    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            rise_q <= '0;
            rise_v <= 1'b0;
            hi_hold <= '0;
            hv_hold <= 1'b0;
        end else begin
            rise_q <= cl25 ? s2_hi : s1_lo;
            rise_v <= cl25 ? s2_v : s1_v;
            hi_hold <= s1_hi;
            hv_hold <= s1_v;
        end
    end

    always_ff @(negedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            fall_q <= '0;
            fall_v <= 1'b0;
        end else begin
            fall_q <= cl25 ? s2_lo : hi_hold;
            fall_v <= cl25 ? s2_v : hv_hold;
        end
    end

    // high impedance unless reading
    // The clock steers the half-cycle mux; a real part would use a DDR output cell
    assign dq_out = ck ? rise_q : fall_q;
    assign dq_oe_n = !(ck ? rise_v : fall_v);
    assign dqs_out = cl25 ? !ck : ck;
    assign dqs_oe_n = dq_oe_n;

    // Write data: first half on the rising edge after the command edge
    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            wr_lo <= '0;
            wr_v <= 1'b0;
            wr_a <= '0;
            wr_b <= '0;
        end else begin
            wr_lo <= dq_in;
            wr_v <= gen_active && burst_wr;
            wr_a <= mem_a;
            wr_b <= mem_b;
        end
    end

    always_ff @(negedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            wr_hi <= '0;
        end else begin
            wr_hi <= dq_in;
        end
    end

    // only write bursts change the array
    always_ff @(posedge ck) begin
        if (wr_v) begin
            mem[wr_a] <= wr_lo;
            mem[wr_b] <= wr_hi;
        end
    end

    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            mrs_tog <= 1'b0;
        end else if (cmd == DDRMI_MRS) begin
            mrs_tog <= !mrs_tog;
        end
    end

    // Registered so that no glitch of the count compare reaches the synchroniser
    always_ff @(posedge ck or negedge rst_link_n) begin
        if (!rst_link_n) begin
            lock_done <= 1'b0;
        end else begin
            lock_done <= ext_mr[EMR_DLL] && lock_cnt == DLL_LOCK_CYC;
        end
    end

    // Status crosses into the system clock domain
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tog_sync <= 3'h0;
            en_sync <= 2'h0;
            lock_sync <= 2'h0;
        end else begin
            tog_sync <= {tog_sync[1:0], mrs_tog};
            en_sync <= {en_sync[0], ext_mr[EMR_DLL]};
            lock_sync <= {lock_sync[0], lock_done};
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mode_load_pulse <= 1'b0;
            dll_enabled <= 1'b0;
            dll_locked <= 1'b0;
        end else begin
            mode_load_pulse <= tog_sync[2] ^ tog_sync[1];
            dll_enabled <= en_sync[1];
            dll_locked <= lock_sync[1];
        end
    end

    AST_CL2_LATENCY: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_RD && !cl25 ##1 cmd != DDRMI_MRS |=> ##1 rise_v)
        else $error("latency two first data late");
    AST_CL25_LATENCY: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_RD && cl25 && !rise_v ##1 cmd != DDRMI_MRS ##1 cmd != DDRMI_MRS |-> ##1 !rise_v ##1 rise_v)
        else $error("latency two and a half mistimed");
    AST_PREFETCH_PAIR: assert property (@(posedge ck) disable iff (!rst_link_n)
        s1_v && !cl25 |=> rise_q == $past(s1_lo) && hi_hold == $past(s1_hi))
        else $error("prefetch halves misplaced");
    AST_IDLE_HIZ: assert property (@(posedge ck) disable iff (!rst_link_n)
        !s1_v && !s2_v |=> !rise_v)
        else $error("output enabled without read");
    AST_BASE_STORE: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_MRS && ba == BA_BASE |=> base_mr[MR_CL_MSB:0] == $past(addr[MR_CL_MSB:0]))
        else $error("base mode not stored");
    AST_DLLRST_CLEAR: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_MRS && ba == BA_BASE && addr[MR_DLLRST] |=> !base_mr[MR_DLLRST] && lock_cnt == 8'h00)
        else $error("DLL reset bit not self clearing");
    AST_EXT_STORE: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_MRS && ba == BA_EXT |=> ext_mr[EMR_DLL] == $past(addr[EMR_DLL]) && base_mr == $past(base_mr))
        else $error("extended mode not stored");
    AST_REFRESH_KEEP: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_MRS |=> refresh_row == $past(refresh_row))
        else $error("mode load moved refresh counter");
    AST_ROW_OPEN: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_ACT |=> row_open[$past(ba)] && open_row[$past(ba)] == $past(addr))
        else $error("row not opened");
    AST_MRS_NO_WRITE: assert property (@(posedge ck) disable iff (!rst_link_n)
        cmd == DDRMI_MRS && !gen_active |=> !wr_v)
        else $error("mode load wrote the array");
    CV_READ_CL2: cover property (@(posedge ck) disable iff (!rst_link_n) cmd == DDRMI_RD && !cl25);
    CV_READ_CL25: cover property (@(posedge ck) disable iff (!rst_link_n) cmd == DDRMI_RD && cl25);
    CV_WRITE: cover property (@(posedge ck) disable iff (!rst_link_n) wr_v);
endmodule
`default_nettype wire

// *** test/ddrmi_ctl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddrmi_ctl_model (
    output logic ck,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [ddrmi_pkg::BA_W-1:0] ba,
    output logic [ddrmi_pkg::ADDR_W-1:0] addr,
    output logic [ddrmi_pkg::DQ_W-1:0] dq_drv
);
    import ddrmi_pkg::*;

    // Odd start offset keeps the memory clock out of phase with sys_clk
    initial begin
        ck = 1'b0;
        #3.7;
        forever #16 ck = ~ck;
    end

    initial begin
        cke = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        ba = 2'h0;
        addr = 13'h0000;
        dq_drv = 8'h00;
    end

    function automatic logic [2:0] pins_of(input ddrmi_cmd_t c);
        case (c)
            DDRMI_ACT: return 3'h3;
            DDRMI_RD: return 3'h5;
            DDRMI_WR: return 3'h4;
            DDRMI_BST: return 3'h6;
            DDRMI_PRE: return 3'h2;
            DDRMI_REF: return 3'h1;
            DDRMI_MRS: return 3'h0;
            default: return 3'h7;
        endcase
    endfunction

    // Held from one rising edge to the next, where it is taken
    task automatic issue(input ddrmi_cmd_t c, input logic [1:0] b, input logic [12:0] a);
        @(posedge ck);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= pins_of(c);
        ba <= b;
        addr <= a;
        @(posedge ck);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= 3'h7;
        ba <= ~b;
        addr <= ~a;
    endtask

    // Loads only with all banks idle
    task automatic load_mode(input logic [1:0] b, input logic [12:0] a);
        issue(DDRMI_PRE, 2'h0, 13'h0400);
        issue(DDRMI_MRS, b, a);
        repeat (2) @(posedge ck);
    endtask

    task automatic init_a(input logic [12:0] mr);
        repeat (6251) @(posedge ck);
        // CKE high, NOP, PALL, EMRS, MRS
        cke <= 1'b1;
        issue(DDRMI_NOP, 2'h0, 13'h0000);
        load_mode(BA_EXT, 13'h0001);
        issue(DDRMI_MRS, BA_BASE, mr | 13'h0100);
    endtask

    task automatic init_b(input logic [12:0] mr);
        issue(DDRMI_PRE, 2'h0, 13'h0400);
        repeat (2) issue(DDRMI_REF, 2'h0, 13'h0000);
        issue(DDRMI_MRS, BA_BASE, mr);
        repeat (2) @(posedge ck);
    endtask

    // First byte at the edge after Write, then one every half clock
    task automatic write8(input logic [1:0] b, input logic [9:0] col, input logic [63:0] d);
        int j;
        issue(DDRMI_WR, b, {3'h0, col});
        dq_drv <= d[7:0];
        for (j = 1; j < 8; j++) begin
            if (j % 2 == 1)
                @(posedge ck);
            else
                @(negedge ck);
            dq_drv <= d[8*j +: 8];
        end
        @(posedge ck);
        dq_drv <= ~d[63:56];
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ddrmi_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ck, cke, cs_n, ras_n, cas_n, we_n;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0] dq_in, dq_out;
    logic dq_oe_n, dqs_out, dqs_oe_n, dll_enabled, dll_locked, mode_load_pulse;
    logic [7:0] mem [4][16];
    logic [7:0] exp_q [$];
    logic [15:0] lfsr = 16'he407;
    int fail_count = 0;
    int num_checks = 0;
    int mrs_seen = 0;
    int cycles = 0;
    logic cur_cl25 = 1'b0;

    always #4 sys_clk = ~sys_clk;

    ddrmi_ctl_model u_ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .ba(ba), .addr(addr), .dq_drv(dq_in));

    ddrmi_device u_dut (.sys_clk(sys_clk), .resetn(resetn), .ck(ck), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n),
        .dll_enabled(dll_enabled), .dll_locked(dll_locked), .mode_load_pulse(mode_load_pulse));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [12:0] mr_val(input logic [2:0] blc, input logic il, input logic [2:0] clc);
        return {6'h00, clc, il, blc};
    endfunction

    function automatic logic [3:0] burst_col(input logic [3:0] st, input int n, input logic il, input int k);
        logic [3:0] m;
        m = 4'(n - 1);
        return (st & ~m) | ((il ? (st ^ 4'(k)) : (st + 4'(k))) & m);
    endfunction

    // Mid-half sampling: the mux output is settled there on either edge
    always @(posedge ck or negedge ck) begin
        #8;
        if (dq_oe_n === 1'b0) begin
            if (exp_q.size() == 0)
                check("unexpected read byte", 32'h1, 32'h0);
            else
                check("read byte", exp_q.pop_front(), dq_out);
            check("dqs_oe_n", 32'h0, dqs_oe_n);
            check("dqs_out", 32'(ck ^ cur_cl25), dqs_out);
        end
    end

    always @(posedge sys_clk) begin
        if (mode_load_pulse === 1'b1)
            mrs_seen <= mrs_seen + 1;
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            check("timeout", 32'h0, 32'h1);
            end_of_test();
        end
    end

    task automatic wr_block(input logic [1:0] b, input logic [3:0] st, input logic il);
        logic [63:0] d;
        int k;
        for (k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            d[16*k +: 16] = lfsr;
        end
        u_ctl.load_mode(BA_BASE, mr_val(BL_8, il, CL_2));
        u_ctl.issue(DDRMI_ACT, b, 13'h0003);
        u_ctl.write8(b, {6'h00, st}, d);
        for (k = 0; k < 8; k++)
            mem[b][burst_col(st, 8, il, k)] = d[8*k +: 8];
        $display("write block bank %0d start %0d done", b, st);
    endtask

    task automatic rd(input logic [1:0] b, input logic [3:0] st, input int n, input logic il, input logic cl25);
        int k;
        int first;
        first = cl25 ? 5 : 4;
        cur_cl25 = cl25;
        u_ctl.load_mode(BA_BASE, mr_val(n == 2 ? BL_2 : n == 4 ? BL_4 : BL_8, il, cl25 ? CL_25 : CL_2));
        // A load with a reserved select must leave the settings alone
        u_ctl.issue(DDRMI_MRS, 2'h2, mr_val(BL_8, ~il, cl25 ? CL_2 : CL_25));
        u_ctl.issue(DDRMI_ACT, b, 13'h0003);
        for (k = 0; k < n; k++)
            exp_q.push_back(mem[b][burst_col(st, n, il, k)]);
        u_ctl.issue(DDRMI_RD, b, {9'h000, st});
        #8;
        repeat (first - 1) #16;
        check("oe_n before first data", 32'h1, dq_oe_n);
        #16;
        check("oe_n at first data", 32'h0, dq_oe_n);
        repeat (n + 4) @(posedge ck);
        #8;
        check("bytes left", 32'h0, exp_q.size());
        check("oe_n after burst", 32'h1, dq_oe_n);
    endtask

    initial begin
        int i;
        logic [1:0] b;
        repeat (12) @(posedge sys_clk);
        check("dq_oe_n in reset", 32'h1, dq_oe_n);
        check("dqs_oe_n in reset", 32'h1, dqs_oe_n);
        check("dll_enabled in reset", 32'h0, dll_enabled);
        resetn <= 1'b1;
        $display("reset test done");
        u_ctl.init_a(mr_val(BL_8, 1'b0, CL_2));
        repeat (190) @(posedge ck);
        check("dll_enabled", 32'h1, dll_enabled);
        check("dll_locked early", 32'h0, dll_locked);
        repeat (12) @(posedge ck);
        check("dll_locked", 32'h1, dll_locked);
        u_ctl.init_b(mr_val(BL_8, 1'b0, CL_2));
        check("dll_locked after normal load", 32'h1, dll_locked);
        check("mode loads seen", 32'h3, mrs_seen);
        $display("init test done");
        wr_block(2'h1, 4'h0, 1'b0);
        wr_block(2'h2, 4'h0, 1'b0);
        wr_block(2'h2, 4'hd, 1'b1);
        for (i = 0; i < 24; i++) begin
            lfsr = lfsr_next(lfsr);
            b = (i % 2 == 1) ? 2'h1 : 2'h2;
            rd(b, lfsr[3:0] & (b == 2'h1 ? 4'h7 : 4'hf), 2 << (i % 3), ((i / 3) % 2) == 1, ((i / 6) % 2) == 1);
            $display("read test %0d done", i);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
